/* File: src/cmctl_decode.sv */
// combinational decoder of maintenance write commands
`timescale 1ns/1ps
`include "cmctl_map.svh"
module cmctl_decode
(
  input  wire logic                  i_wr,
  input  wire cmctl_pkg::cmctl_cmd_s i_cmd,
  output cmctl_pkg::cmctl_op_s       o_op
);
  logic c7;
  logic c8;
  logic c9;
  logic c10;
  logic o0;
  logic o1;
  assign c7  = i_wr && i_cmd.crn == `CMCTL_CRN_CACHE;
  assign c8  = i_wr && i_cmd.crn == `CMCTL_CRN_TLB;
  assign c9  = i_wr && i_cmd.crn == `CMCTL_CRN_CLOCK;
  assign c10 = i_wr && i_cmd.crn == `CMCTL_CRN_TLOCK;
  assign o0  = i_cmd.op2 == `CMCTL_OP_0;
  assign o1  = i_cmd.op2 == `CMCTL_OP_1;

  always_comb
  begin
    o_op = '0;
    // whole caches; inv of one icache line never touches the btb
    o_op.inv_icache = c7 && o0 && (i_cmd.sel == `CMCTL_SEL_ALL ||
                      i_cmd.sel == `CMCTL_SEL_INS); // see [RULE10]
    o_op.inv_dcache = c7 && o0 && (i_cmd.sel == `CMCTL_SEL_ALL ||
                      i_cmd.sel == `CMCTL_SEL_DAT); // see [RULE10]
    o_op.inv_btb    = o_op.inv_icache || (c7 &&
                      i_cmd.op2 == `CMCTL_OP_BTB &&
                      i_cmd.sel == `CMCTL_SEL_INS); // see [RULE7]
    o_op.inv_iline  = c7 && o1 && i_cmd.sel == `CMCTL_SEL_INS; // see [RULE11]
    o_op.inv_dline  = c7 && o1 && i_cmd.sel == `CMCTL_SEL_DAT; // see [RULE11]
    o_op.clean_dline = c7 && o1 && i_cmd.sel == `CMCTL_SEL_CLEAN;
    o_op.drain = c7 && i_cmd.op2 == `CMCTL_OP_DRAIN &&
                 i_cmd.sel == `CMCTL_SEL_CLEAN; // see [RULE5]
    o_op.alloc = c7 && i_cmd.op2 == `CMCTL_OP_ALLOC &&
                 i_cmd.sel == `CMCTL_SEL_ALLOC; // see [RULE12]
    o_op.inv_itlb = c8 && o0 && (i_cmd.sel == `CMCTL_SEL_ALL ||
                    i_cmd.sel == `CMCTL_SEL_INS); // see [RULE16]
    o_op.inv_dtlb = c8 && o0 && (i_cmd.sel == `CMCTL_SEL_ALL ||
                    i_cmd.sel == `CMCTL_SEL_DAT); // see [RULE16]
    o_op.inv_itlb_ent = c8 && o1 && i_cmd.sel == `CMCTL_SEL_INS;
    o_op.inv_dtlb_ent = c8 && o1 && i_cmd.sel == `CMCTL_SEL_DAT;
    o_op.lock_iline    = c9 && o0 && i_cmd.sel == `CMCTL_SEL_ILOCK; // see [RULE17]
    o_op.unlock_icache = c9 && o1 && i_cmd.sel == `CMCTL_SEL_ILOCK; // see [RULE17]
    o_op.unlock_dcache = c9 && o1 && i_cmd.sel == `CMCTL_SEL_DLOCK; // see [RULE18]
    o_op.lock_itlb   = c10 && o0 && i_cmd.sel == `CMCTL_SEL_ITLBL; // see [RULE20]
    o_op.lock_dtlb   = c10 && o0 && i_cmd.sel == `CMCTL_SEL_DTLBL; // see [RULE20]
    o_op.unlock_itlb = c10 && o1 && i_cmd.sel == `CMCTL_SEL_ITLBL; // see [RULE20]
    o_op.unlock_dtlb = c10 && o1 && i_cmd.sel == `CMCTL_SEL_DTLBL; // see [RULE20]
  end
endmodule

/* File: src/cmctl_fault.sv */
// fault status and fault address registers
`timescale 1ns/1ps
`include "cmctl_map.svh"
module cmctl_fault
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_abort,
  input  wire logic [3:0]  i_abort_domain,
  input  wire logic [3:0]  i_abort_status,
  input  wire logic [31:0] i_abort_addr,
  input  wire logic        i_wr_fsr,
  input  wire logic        i_wr_far,
  input  wire logic [31:0] i_wdata,
  output logic [31:0]      o_fsr,
  output logic [31:0]      o_far
);
  // an abort in the same cycle as a software write wins
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_fsr <= `CMCTL_FSR_RESET;
    else if (i_abort)
      o_fsr <= {24'h0, i_abort_domain, i_abort_status}; // see [RULE1] [RULE2]
    else if (i_wr_fsr)
      o_fsr <= i_wdata & `CMCTL_FSR_WMASK; // see [RULE2]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_far <= `CMCTL_FAR_RESET;
    else if (i_abort)
      o_far <= i_abort_addr; // see [RULE3]
    else if (i_wr_far)
      o_far <= i_wdata;
  end
endmodule

/* File: src/cmctl_map.svh */
// register selectors, command codes and field positions of the maintenance block
`ifndef CMCTL_MAP_SVH
`define CMCTL_MAP_SVH
`define CMCTL_CRN_FSR      4'h5
`define CMCTL_CRN_FAR      4'h6
`define CMCTL_CRN_CACHE    4'h7
`define CMCTL_CRN_TLB      4'h8
`define CMCTL_CRN_CLOCK    4'h9
`define CMCTL_CRN_TLOCK    4'ha
`define CMCTL_OP_0         3'h0
`define CMCTL_OP_1         3'h1
`define CMCTL_OP_DRAIN     3'h4
`define CMCTL_OP_ALLOC     3'h5
`define CMCTL_OP_BTB       3'h6
`define CMCTL_SEL_ALL      4'h7
`define CMCTL_SEL_INS      4'h5
`define CMCTL_SEL_DAT      4'h6
`define CMCTL_SEL_CLEAN    4'ha
`define CMCTL_SEL_ALLOC    4'h2
`define CMCTL_SEL_ILOCK    4'h1
`define CMCTL_SEL_DLOCK    4'h2
`define CMCTL_SEL_ITLBL    4'h4
`define CMCTL_SEL_DTLBL    4'h8
`define CMCTL_FSR_DOM_LSB  4
`define CMCTL_FSR_DOM_MSB  7
`define CMCTL_FSR_ST_MSB   3
`define CMCTL_FSR_WMASK    32'h0000_06ff
`define CMCTL_FSR_RESET    32'h0000_0000
`define CMCTL_FAR_RESET    32'h0000_0000
`define CMCTL_LOCK_RESET   1'b0
`define CMCTL_TAG_LSB      5
`endif

/* File: src/cmctl_pkg.sv */
// types shared by the maintenance controller files
package cmctl_pkg;
  typedef struct packed {
    logic [3:0]  crn;
    logic [2:0]  op2;
    logic [3:0]  sel;
    logic [31:0] data;
  } cmctl_cmd_s;

  typedef struct packed {
    logic inv_icache;
    logic inv_dcache;
    logic inv_btb;
    logic inv_iline;
    logic inv_dline;
    logic clean_dline;
    logic drain;
    logic alloc;
    logic inv_itlb;
    logic inv_dtlb;
    logic inv_itlb_ent;
    logic inv_dtlb_ent;
    logic lock_iline;
    logic unlock_icache;
    logic unlock_dcache;
    logic lock_itlb;
    logic lock_dtlb;
    logic unlock_itlb;
    logic unlock_dtlb;
  } cmctl_op_s;

  typedef enum logic [1:0] {
    CMCTL_IDLE  = 2'b00,
    CMCTL_WAIT  = 2'b01,
    CMCTL_EVICT = 2'b11,
    CMCTL_PLACE = 2'b10
  } cmctl_alloc_e;
endpackage

/* File: src/cmctl_top.sv */
// cache and tlb maintenance controller top
// Operation
// [RULE1] data abort records accessed domain in fault status bits 7:4
// [RULE2] fault status bits 3:0 give access type; bit 8 reads zero
// [RULE3] fault address register captures the aborting access address
// [RULE4] core only writes command registers; only lock mode is readable
// [RULE5] drain command empties write buffer and fill buffer together
// [RULE6] maintenance commands never raise translation, domain or permission faults
// [RULE7] single icache line invalidate leaves the branch target buffer alone
// [RULE8] cache enable does not alter contents; commands work regardless
// [RULE9] only clean data line may report a parity fault
// [RULE10] function 0 selectors 7,5,6 invalidate whole caches and branch buffer
// [RULE11] function 1 invalidates or cleans one line at the address
// [RULE12] allocate places tag from bits 31:5, evicting a dirty other line
// [RULE13] allocated line is clean; later store marks it dirty
// [RULE14] allocate waits for pending ops, skips resident lines, not mini cache
// [RULE15] translation enable does not alter tlbs; tlb commands work anyway
// [RULE16] function 0 invalidates whole tlbs, function 1 one entry
// [RULE17] function 0 selector 1 locks icache line, function 1 unlocks all
// [RULE18] lock mode bit 0 locks every data fill; unlock data cache
// [RULE19] core must not lock or unlock a disabled cache
// [RULE20] selectors 4 and 8 lock or unlock instruction or data tlb
// [RULE21] core must not issue tlb lock commands with translation off
// [RULE22] core treats registers 11 and 12 as reserved
`timescale 1ns/1ps
`include "cmctl_map.svh"
module cmctl_top
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_cp_wr,
  input  wire logic                  i_cp_rd,
  input  wire cmctl_pkg::cmctl_cmd_s i_cp_cmd,
  input  wire logic                  i_abort,
  input  wire logic [3:0]            i_abort_domain,
  input  wire logic [3:0]            i_abort_status,
  input  wire logic [31:0]           i_abort_addr,
  input  wire logic                  i_mem_idle,
  input  wire logic                  i_line_resident,
  input  wire logic                  i_victim_dirty,
  input  wire logic                  i_evict_done,
  input  wire logic                  i_dfill,
  input  wire logic                  i_clean_parity_err,
  output logic [31:0]                o_rdata,
  output logic                       o_busy,
  output logic [31:0]                o_fault_status,
  output logic [31:0]                o_fault_address,
  output cmctl_pkg::cmctl_op_s       o_op,
  output logic [31:0]                o_op_addr,
  output logic                       o_evict,
  output logic                       o_place_tag,
  output logic [26:0]                o_tag,
  output logic                       o_fill_lock,
  output logic                       o_parity_fault,
  output logic                       o_lock_mode
);
  cmctl_pkg::cmctl_op_s     op_d;
  cmctl_pkg::cmctl_alloc_e  st_q;
  logic                     wr_fsr;
  logic                     wr_far;
  logic                     wr_lock;
  logic                     take;
  logic [26:0]              tag_q;

  // ==========================================================
  // command decode
  // ==========================================================
  // a new write is only taken while no allocation is in flight
  assign take = i_cp_wr && st_q == cmctl_pkg::CMCTL_IDLE;

  cmctl_decode u_decode
  (
    .i_wr  (take),
    .i_cmd (i_cp_cmd),
    .o_op  (op_d)
  );

  assign wr_fsr  = take && i_cp_cmd.crn == `CMCTL_CRN_FSR;
  assign wr_far  = take && i_cp_cmd.crn == `CMCTL_CRN_FAR;
  assign wr_lock = take && i_cp_cmd.crn == `CMCTL_CRN_CLOCK &&
                   i_cp_cmd.op2 == `CMCTL_OP_0 &&
                   i_cp_cmd.sel == `CMCTL_SEL_DLOCK;

  // ==========================================================
  // operation strobes
  // ==========================================================
  // strobes ignore cache and mmu enables: those never gate maintenance
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_op <= '0;
    else
    begin
      o_op <= op_d; // see [RULE8] [RULE15]
      o_op.alloc <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_op_addr <= 32'h0;
    else if (take)
      o_op_addr <= i_cp_cmd.data;
  end

  // ==========================================================
  // fault registers
  // ==========================================================
  // maintenance has no fault path of its own; only aborts and software writes to registers 5 and 6 load these
  cmctl_fault u_fault
  (
    .i_ref_clk      (i_ref_clk),
    .i_rst_n        (i_rst_n),
    .i_abort        (i_abort),
    .i_abort_domain (i_abort_domain),
    .i_abort_status (i_abort_status),
    .i_abort_addr   (i_abort_addr),
    .i_wr_fsr       (wr_fsr),
    .i_wr_far       (wr_far),
    .i_wdata        (i_cp_cmd.data),
    .o_fsr          (o_fault_status),
    .o_far          (o_fault_address)
  ); // see [RULE6]

  // parity fault only from the clean-line read
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_parity_fault <= 1'b0;
    else
      o_parity_fault <= o_op.clean_dline && i_clean_parity_err; // see [RULE9]
  end

  // ==========================================================
  // lock mode and readback
  // ==========================================================
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_lock_mode <= `CMCTL_LOCK_RESET;
    else if (wr_lock)
      o_lock_mode <= i_cp_cmd.data[0];
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_fill_lock <= 1'b0;
    else
      o_fill_lock <= i_dfill && o_lock_mode; // see [RULE18]
  end

  // reads of command registers are undefined; only lock mode answers
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      o_rdata <= 32'h0;
    else if (i_cp_rd)
    begin
      case (i_cp_cmd.crn)
        `CMCTL_CRN_FSR:   o_rdata <= o_fault_status;
        `CMCTL_CRN_FAR:   o_rdata <= o_fault_address;
        `CMCTL_CRN_CLOCK: o_rdata <= {31'h0, o_lock_mode}; // see [RULE4]
        default:          o_rdata <= 32'h0;
      endcase
    end
  end

  // ==========================================================
  // line allocation sequencer
  // ==========================================================
  // mini data cache has no path here: the tag goes to the main array only
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      st_q <= cmctl_pkg::CMCTL_IDLE;
    else
    begin
      case (st_q)
        cmctl_pkg::CMCTL_IDLE:
          if (op_d.alloc)
            st_q <= cmctl_pkg::CMCTL_WAIT;
        cmctl_pkg::CMCTL_WAIT:
          if (i_mem_idle) // see [RULE14]
          begin
            if (i_line_resident)
              st_q <= cmctl_pkg::CMCTL_IDLE; // see [RULE14]
            else if (i_victim_dirty)
              st_q <= cmctl_pkg::CMCTL_EVICT; // see [RULE12]
            else
              st_q <= cmctl_pkg::CMCTL_PLACE;
          end
        cmctl_pkg::CMCTL_EVICT:
          if (i_evict_done)
            st_q <= cmctl_pkg::CMCTL_PLACE;
        cmctl_pkg::CMCTL_PLACE:
          st_q <= cmctl_pkg::CMCTL_IDLE;
        default:
          st_q <= cmctl_pkg::CMCTL_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      tag_q <= 27'h0;
    else if (op_d.alloc)
      tag_q <= i_cp_cmd.data[31:`CMCTL_TAG_LSB]; // see [RULE12]
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      o_evict     <= 1'b0;
      o_place_tag <= 1'b0;
      o_tag       <= 27'h0;
      o_busy      <= 1'b0;
    end
    else
    begin
      o_evict <= st_q == cmctl_pkg::CMCTL_WAIT && i_mem_idle &&
                 !i_line_resident && i_victim_dirty;
      // placed line is clean; the cache sets dirty on a later store
      o_place_tag <= st_q == cmctl_pkg::CMCTL_PLACE; // see [RULE13]
      o_tag       <= tag_q;
      o_busy      <= (st_q != cmctl_pkg::CMCTL_IDLE || op_d.alloc) &&
                     !(st_q == cmctl_pkg::CMCTL_PLACE) &&
                     !(st_q == cmctl_pkg::CMCTL_WAIT && i_mem_idle &&
                       i_line_resident);
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  sequence s_alloc_req;
    take && op_d.alloc;
  endsequence

  sequence s_alloc_place;
    ##[1:1000] o_place_tag;
  endsequence

  AST_DRAIN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE5]
    take && i_cp_cmd.crn == `CMCTL_CRN_CACHE &&
    i_cp_cmd.op2 == `CMCTL_OP_DRAIN && i_cp_cmd.sel == `CMCTL_SEL_CLEAN
    |=> o_op.drain)
    else $error("drain strobe missing");

  AST_ILINE_NO_BTB: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE7]
    o_op.inv_iline |-> !o_op.inv_btb)
    else $error("line invalidate touched btb");

  AST_INV_ALL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE10]
    take && i_cp_cmd.crn == `CMCTL_CRN_CACHE && i_cp_cmd.op2 == `CMCTL_OP_0 &&
    i_cp_cmd.sel == `CMCTL_SEL_ALL
    |=> o_op.inv_icache && o_op.inv_dcache && o_op.inv_btb)
    else $error("full invalidate incomplete");

  AST_PARITY: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE9]
    o_parity_fault |-> $past(o_op.clean_dline))
    else $error("parity fault from other command");

  AST_FSR_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE1]
    i_abort |=> o_fault_status[7:4] == $past(i_abort_domain) &&
    o_fault_status[8] == 1'b0)
    else $error("fault domain not captured");

  AST_FAR_CAPTURE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE3]
    i_abort |=> o_fault_address == $past(i_abort_addr))
    else $error("fault address not captured");

  AST_FILL_LOCK: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE18]
    i_dfill |=> o_fill_lock == $past(o_lock_mode))
    else $error("fill lock mismatch");

  // the memory side is never idle in the cycle after the request, so the
  // clean-slot path is checked from the wait state itself
  AST_ALLOC_DONE: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE12]
    st_q == cmctl_pkg::CMCTL_WAIT &&
    i_mem_idle && !i_line_resident && !i_victim_dirty
    |-> ##2 o_place_tag)
    else $error("allocate did not place tag");

  AST_RESIDENT: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE14]
    st_q == cmctl_pkg::CMCTL_WAIT && i_mem_idle && i_line_resident
    |=> st_q == cmctl_pkg::CMCTL_IDLE [*2])
    else $error("resident line was allocated");

  AST_WAIT_MEM: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE14]
    st_q == cmctl_pkg::CMCTL_WAIT && !i_mem_idle
    |=> st_q == cmctl_pkg::CMCTL_WAIT)
    else $error("allocate ran before memory idle");

  AST_PLACE_TAG: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE13]
    o_place_tag |-> o_tag == tag_q && !o_evict)
    else $error("placed tag wrong");

  AST_TLB_ALL: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE16]
    take && i_cp_cmd.crn == `CMCTL_CRN_TLB && i_cp_cmd.op2 == `CMCTL_OP_0 &&
    i_cp_cmd.sel == `CMCTL_SEL_ALL |=> o_op.inv_itlb && o_op.inv_dtlb)
    else $error("tlb invalidate incomplete");

  AST_ALLOC_BOUND: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // see [RULE12]
    s_alloc_req ##1 (!i_line_resident && !i_victim_dirty)
    |-> s_alloc_place)
    else $error("allocate never finished");
endmodule

/* File: test/cache_tlb_maintenance_ctrl_bench.sv */
// self-checking bench of the maintenance controller
`timescale 1ns/1ps
module cache_tlb_maintenance_ctrl_bench;
  logic                  i_ref_clk;
  logic                  i_rst_n;
  logic                  i_cp_wr;
  logic                  i_cp_rd;
  cmctl_pkg::cmctl_cmd_s i_cp_cmd;
  logic                  i_abort;
  logic [3:0]            i_abort_domain;
  logic [3:0]            i_abort_status;
  logic [31:0]           i_abort_addr;
  logic                  mem_idle, line_res, victim_dirty, evict_done;
  logic                  i_dfill;
  logic                  i_clean_parity_err;
  logic [31:0]           o_rdata, o_fault_status, o_fault_address;
  logic [31:0]           o_op_addr;
  logic                  o_busy, o_evict, o_place_tag;
  logic                  o_fill_lock, o_parity_fault, o_lock_mode;
  logic [26:0]           o_tag;
  cmctl_pkg::cmctl_op_s  o_op;
  logic [3:0]            hold;
  logic                  cfg_res, cfg_dirty;
  int                    error_cnt, checked;

  always #2 i_ref_clk = ~i_ref_clk;

  cmctl_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_cp_wr(i_cp_wr), .i_cp_rd(i_cp_rd), .i_cp_cmd(i_cp_cmd),
    .i_abort(i_abort), .i_abort_domain(i_abort_domain),
    .i_abort_status(i_abort_status), .i_abort_addr(i_abort_addr),
    .i_mem_idle(mem_idle), .i_line_resident(line_res),
    .i_victim_dirty(victim_dirty), .i_evict_done(evict_done),
    .i_dfill(i_dfill), .i_clean_parity_err(i_clean_parity_err),
    .o_rdata(o_rdata), .o_busy(o_busy), .o_fault_status(o_fault_status),
    .o_fault_address(o_fault_address), .o_op(o_op), .o_op_addr(o_op_addr),
    .o_evict(o_evict), .o_place_tag(o_place_tag), .o_tag(o_tag),
    .o_fill_lock(o_fill_lock), .o_parity_fault(o_parity_fault),
    .o_lock_mode(o_lock_mode));

  cmctl_mem_model mem (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_busy(o_busy), .i_evict(o_evict), .i_hold(hold), .i_res(cfg_res),
    .i_dirty(cfg_dirty), .o_mem_idle(mem_idle),
    .o_line_resident(line_res), .o_victim_dirty(victim_dirty),
    .o_evict_done(evict_done));

  // ==========================================================
  // access tasks
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge i_ref_clk);
    #1;
  endtask

  // one-cycle write strobe; returns in the cycle the answer stands
  task automatic wr(input logic [3:0] crn, input logic [2:0] op2,
                    input logic [3:0] sel, input logic [31:0] data);
    i_cp_wr  = 1'b1;
    i_cp_cmd = '{crn, op2, sel, data};
    tick;
    i_cp_wr  = 1'b0;
  endtask

  task automatic rd(input logic [3:0] crn, input logic [31:0] exp);
    i_cp_rd      = 1'b1;
    i_cp_cmd.crn = crn;
    tick;
    i_cp_rd = 1'b0;
    chk(o_rdata, exp);
  endtask

  // parity error input is held high in the first command run: only clean line may report it
  task automatic cmd(input logic [3:0] crn, input logic [2:0] op2,
                     input logic [3:0] sel, input logic [18:0] exp);
    logic [31:0] d;
    d = {12'hf0e, crn, 1'b0, op2, sel, 8'h3c};
    wr(crn, op2, sel, d);
    chk({13'h0, o_op}, {13'h0, exp});
    chk(o_op_addr, d);
    tick;
    chk({31'h0, o_parity_fault}, {31'h0, exp == 19'h02000});
  endtask

  task automatic alloc(input logic [31:0] a, input logic [3:0] h,
                       input logic res, input logic dirty);
    int n;
    int ev;
    int pl;
    hold      = h;
    cfg_res   = res;
    cfg_dirty = dirty;
    ev        = 0;
    pl        = 0;
    wr(4'h7, 3'h5, 4'h2, a);
    for (n = 0; n < 40 && o_busy === 1'b1; n++)
    begin
      tick;
      if (o_evict === 1'b1)
        ev++;
      if (o_place_tag === 1'b1)
      begin
        pl++;
        chk({5'h0, o_tag}, {5'h0, a[31:5]});
      end
    end
    if (n == 40)
    begin
      chk(32'h0, 32'h1);
      summarize;
    end
    chk(ev, {31'h0, dirty && !res});
    chk(pl, {31'h0, !res});
    if (!res)
      chk({31'h0, n > h}, 32'h1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    i_ref_clk = 1'b0;
    i_rst_n = 1'b0;
    i_cp_wr = 1'b0;
    i_cp_rd = 1'b0;
    i_cp_cmd = '0;
    i_abort = 1'b0;
    i_abort_domain = 4'h0;
    i_abort_status = 4'h0;
    i_abort_addr = 32'h0;
    i_dfill = 1'b0;
    i_clean_parity_err = 1'b1;
    hold = 4'h0;
    cfg_res = 1'b0;
    cfg_dirty = 1'b0;
    error_cnt = 0;
    checked = 0;
    repeat (3) @(posedge i_ref_clk);
    #1;
    i_rst_n = 1'b1;
    chk({31'h0, o_lock_mode}, 32'h0);
    // caches and translation count as enabled; registers 11 and 12 unused
    cmd(4'h7, 3'h0, 4'h7, 19'h70000);
    cmd(4'h7, 3'h0, 4'h5, 19'h50000);
    cmd(4'h7, 3'h0, 4'h6, 19'h20000);
    cmd(4'h7, 3'h1, 4'h5, 19'h08000);
    cmd(4'h7, 3'h1, 4'h6, 19'h04000);
    cmd(4'h7, 3'h1, 4'ha, 19'h02000);
    cmd(4'h7, 3'h4, 4'ha, 19'h01000);
    cmd(4'h7, 3'h6, 4'h5, 19'h10000);
    cmd(4'h7, 3'h2, 4'h7, 19'h00000);
    cmd(4'h8, 3'h0, 4'h7, 19'h00600);
    cmd(4'h8, 3'h0, 4'h5, 19'h00400);
    cmd(4'h8, 3'h0, 4'h6, 19'h00200);
    cmd(4'h8, 3'h1, 4'h5, 19'h00100);
    cmd(4'h8, 3'h1, 4'h6, 19'h00080);
    cmd(4'h9, 3'h0, 4'h1, 19'h00040);
    cmd(4'h9, 3'h1, 4'h1, 19'h00020);
    cmd(4'h9, 3'h1, 4'h2, 19'h00010);
    cmd(4'ha, 3'h0, 4'h4, 19'h00008);
    cmd(4'ha, 3'h0, 4'h8, 19'h00004);
    cmd(4'ha, 3'h1, 4'h4, 19'h00002);
    cmd(4'ha, 3'h1, 4'h8, 19'h00001);
    chk(o_fault_status, 32'h0);
    chk(o_fault_address, 32'h0);
    i_clean_parity_err = 1'b0;
    // abort capture, then software rewrites of both fault registers
    i_abort = 1'b1;
    i_abort_domain = 4'hb;
    i_abort_status = 4'h6;
    i_abort_addr = 32'h9abc_def4;
    tick;
    i_abort = 1'b0;
    chk(o_fault_status, 32'h0000_00b6);
    // only fault and lock mode registers are read back
    rd(4'h6, 32'h9abc_def4);
    wr(4'h5, 3'h0, 4'h0, 32'hffff_ffff);
    rd(4'h5, 32'h0000_06ff);
    wr(4'h6, 3'h0, 4'h0, 32'h1357_9bdf);
    rd(4'h6, 32'h1357_9bdf);
    // lock mode on: fills lock; lock mode off: fills pass
    wr(4'h9, 3'h0, 4'h2, 32'h0000_0001);
    rd(4'h9, 32'h0000_0001);
    i_dfill = 1'b1;
    tick;
    i_dfill = 1'b0;
    chk({31'h0, o_fill_lock}, 32'h1);
    wr(4'h9, 3'h0, 4'h2, 32'h0000_0000);
    chk({31'h0, o_lock_mode}, 32'h0);
    i_dfill = 1'b1;
    tick;
    i_dfill = 1'b0;
    chk({31'h0, o_fill_lock}, 32'h0);
    alloc(32'hcafe_f0e0, 4'h4, 1'b0, 1'b0);
    alloc(32'h0123_4560, 4'h2, 1'b0, 1'b1);
    alloc(32'h7777_7780, 4'h1, 1'b1, 1'b1);
    cmd(4'h7, 3'h4, 4'ha, 19'h01000);
    summarize;
  end
endmodule

/* File: test/cmctl_mem_model.sv */
// memory-side responder for the line-allocate handshake
`timescale 1ns/1ps
module cmctl_mem_model
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_busy,
  input  wire logic       i_evict,
  input  wire logic [3:0] i_hold,
  input  wire logic       i_res,
  input  wire logic       i_dirty,
  output logic            o_mem_idle,
  output logic            o_line_resident,
  output logic            o_victim_dirty,
  output logic            o_evict_done
);
  logic [3:0] pend_q;
  logic [4:0] ev_q;
  logic       busy_q;

  // ==========================================================
  // pending traffic and eviction latency
  // idle stays low on the first busy cycle so a slow core is modelled
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      pend_q <= 4'h0;
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= i_busy;
      if (i_busy && !busy_q)
        pend_q <= i_hold;
      else if (pend_q != 4'h0)
        pend_q <= pend_q - 4'h1;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      ev_q         <= 5'h0;
      o_evict_done <= 1'b0;
    end
    else
    begin
      o_evict_done <= (ev_q == 5'h1);
      if (i_evict)
        ev_q <= {1'b0, i_hold} + 5'h1;
      else if (ev_q != 5'h0)
        ev_q <= ev_q - 5'h1;
    end
  end

  assign o_mem_idle      = busy_q && (pend_q == 4'h0);
  assign o_line_resident = i_res;
  assign o_victim_dirty  = i_dirty;
endmodule
